// ### rtl/pcg_top.sv
// Peripheral clock gating and stop-mode keep-alive, AXI4-Lite programmed
//
// Register access over AXI4-Lite was chosen for this implementation.
module pcg_top (
   // Clock and reset
   input  wire logic                       CLK_I,
   input  wire logic                       RESET_N_I,
   // AXI4-Lite write channels
   input  wire logic [pcg_pkg::ADDR_W-1:0] AWADDR_I,
   input  wire logic                       AWVALID_I,
   output logic                            AWREADY_O,
   input  wire logic [pcg_pkg::DATA_W-1:0] WDATA_I,
   input  wire logic [3:0]                 WSTRB_I,
   input  wire logic                       WVALID_I,
   output logic                            WREADY_O,
   output logic [1:0]                      BRESP_O,
   output logic                            BVALID_O,
   input  wire logic                       BREADY_I,
   // AXI4-Lite read channels
   input  wire logic [pcg_pkg::ADDR_W-1:0] ARADDR_I,
   input  wire logic                       ARVALID_I,
   output logic                            ARREADY_O,
   output logic [pcg_pkg::DATA_W-1:0]      RDATA_O,
   output logic [1:0]                      RRESP_O,
   output logic                            RVALID_O,
   input  wire logic                       RREADY_I,
   // Power mode handshake with the core
   input  wire logic                       STOP_REQ_I,
   output logic                            STOP_MODE_O,
   output logic                            WAKE_O,
   // Peripheral interrupts, one per enable position
   input  wire logic [pcg_pkg::NUM_A-1:0]  IRQ_A_I,
   input  wire logic [pcg_pkg::NUM_B-1:0]  IRQ_B_I,
   // Peripheral bus selects from the address decoder
   input  wire logic [pcg_pkg::NUM_A-1:0]  PERIPH_SEL_A_I,
   input  wire logic [pcg_pkg::NUM_B-1:0]  PERIPH_SEL_B_I,
   // Gated outputs to the peripherals
   output logic [pcg_pkg::NUM_A-1:0]       CLK_EN_A_O,
   output logic [pcg_pkg::NUM_B-1:0]       CLK_EN_B_O,
   output logic [pcg_pkg::NUM_A-1:0]       PERIPH_SEL_A_O,
   output logic [pcg_pkg::NUM_B-1:0]       PERIPH_SEL_B_O
);

   typedef struct packed {
      logic [pcg_pkg::REG_W-1:0] gate_a;
      logic [pcg_pkg::REG_W-1:0] gate_b;
      logic [pcg_pkg::REG_W-1:0] keep_a;
      logic [1:0]                guard;
      pcg_pkg::pcg_mode_type     mode;
      logic                      in_stop;
      logic                      wake;
   } pcg_top_type;

   pcg_top_type                st;
   pcg_top_type                next_st;
   pcg_pkg::pcg_wr_type        wr;
   logic                       wr_go;
   logic                       wr_hit;
   logic [pcg_pkg::ADDR_W-1:0] rd_addr;
   logic [pcg_pkg::DATA_W-1:0] rd_data;
   logic                       rd_hit;
   logic                       wake_req;
   logic [31:0]                en_all;
   logic [31:0]                keep_all;
   logic [31:0]                sel_in_all;
   logic [31:0]                clk_en_all;
   logic [31:0]                sel_out_all;

   // Byte-lane merge of a 16-bit register; reserved bits forced to zero
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  strb,
                                           input logic [15:0] mask);
      logic [15:0] res;
      res = old;
      if (strb[0]) begin
         res[7:0] = data[7:0];
      end
      if (strb[1]) begin
         res[15:8] = data[15:8];
      end
      return res & mask;
   endfunction : merge16

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave

   pcg_axil_slave u_slave (
      .clk_i     (CLK_I),
      .reset_n_i (RESET_N_I),
      .awaddr_i  (AWADDR_I),
      .awvalid_i (AWVALID_I),
      .awready_o (AWREADY_O),
      .wdata_i   (WDATA_I),
      .wstrb_i   (WSTRB_I),
      .wvalid_i  (WVALID_I),
      .wready_o  (WREADY_O),
      .bresp_o   (BRESP_O),
      .bvalid_o  (BVALID_O),
      .bready_i  (BREADY_I),
      .araddr_i  (ARADDR_I),
      .arvalid_i (ARVALID_I),
      .arready_o (ARREADY_O),
      .rdata_o   (RDATA_O),
      .rresp_o   (RRESP_O),
      .rvalid_o  (RVALID_O),
      .rready_i  (RREADY_I),
      .wr_o      (wr),
      .wr_go_o   (wr_go),
      .wr_hit_i  (wr_hit),
      .rd_addr_o (rd_addr),
      .rd_data_i (rd_data),
      .rd_hit_i  (rd_hit)
   );

   // Address decode; read-only status words refuse writes
   always_comb begin
      wr_hit  = (wr.addr == pcg_pkg::ADDR_GATE_A) || (wr.addr == pcg_pkg::ADDR_GATE_B) ||
                (wr.addr == pcg_pkg::ADDR_KEEP_A) || (wr.addr == pcg_pkg::ADDR_GUARD);
      rd_hit  = 1'b1;
      rd_data = '0;
      case (rd_addr)
         pcg_pkg::ADDR_GATE_A: rd_data = {16'h0000, st.gate_a};
         pcg_pkg::ADDR_GATE_B: rd_data = {16'h0000, st.gate_b};
         pcg_pkg::ADDR_KEEP_A: rd_data = {16'h0000, st.keep_a};
         pcg_pkg::ADDR_GUARD:  rd_data[pcg_pkg::GUARD_LSB +: 2] = st.guard;
         pcg_pkg::ADDR_STATUS: rd_data[pcg_pkg::STAT_STOP] = st.in_stop;
         pcg_pkg::ADDR_LIVE:   rd_data = {CLK_EN_B_O, CLK_EN_A_O};
         default:              rd_hit = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers and power mode

   // Only a clock that is really running can raise a wake-up
   assign wake_req = |(IRQ_A_I & CLK_EN_A_O) | |(IRQ_B_I & CLK_EN_B_O);

   // Register writes, guard and stop/run sequencing
   always_comb begin
      next_st      = st;
      next_st.wake = 1'b0;
      if (wr_go) begin
         case (wr.addr)
            pcg_pkg::ADDR_GATE_A: begin
               if (!st.guard[pcg_pkg::GUARD_ON]) begin
                  next_st.gate_a = merge16(st.gate_a, wr.data, wr.strb,
                                           pcg_pkg::MASK_GATE_A);
               end
            end
            pcg_pkg::ADDR_GATE_B: begin
               if (!st.guard[pcg_pkg::GUARD_ON]) begin
                  next_st.gate_b = merge16(st.gate_b, wr.data, wr.strb,
                                           pcg_pkg::MASK_GATE_B);
               end
            end
            pcg_pkg::ADDR_KEEP_A: begin
               if (!st.guard[pcg_pkg::GUARD_ON]) begin
                  next_st.keep_a = merge16(st.keep_a, wr.data, wr.strb,
                                           pcg_pkg::MASK_KEEP_A);
               end
            end
            pcg_pkg::ADDR_GUARD: begin
               // Once locked only a chip reset frees the guard
               if (!st.guard[pcg_pkg::GUARD_LOCK] && wr.strb[0]) begin
                  next_st.guard = wr.data[pcg_pkg::GUARD_LSB +: 2];
               end
            end
            default: begin
               next_st.guard = st.guard;
            end
         endcase
      end
      case (st.mode)
         pcg_pkg::MODE_RUN: begin
            if (STOP_REQ_I) begin
               next_st.mode = pcg_pkg::MODE_STOP;
            end
         end
         pcg_pkg::MODE_STOP: begin
            if (wake_req) begin
               next_st.mode = pcg_pkg::MODE_RUN;
               next_st.wake = 1'b1;
            end
         end
         default: begin
            next_st.mode = pcg_pkg::MODE_RUN;
         end
      endcase
      next_st.in_stop = (next_st.mode == pcg_pkg::MODE_STOP);
   end

   // State register; all enables come up off
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         st.gate_a  <= pcg_pkg::RST_GATE_A;
         st.gate_b  <= pcg_pkg::RST_GATE_B;
         st.keep_a  <= pcg_pkg::RST_KEEP_A;
         st.guard   <= pcg_pkg::RST_GUARD;
         st.mode    <= pcg_pkg::MODE_RUN;
         st.in_stop <= 1'b0;
         st.wake    <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign STOP_MODE_O = st.in_stop;
   assign WAKE_O      = st.wake;

   ////////////////////////////////////////////////////////////////////////////
   // Per-peripheral gates; group B has no keep register so it always stops

   assign en_all     = {st.gate_b, st.gate_a};
   assign keep_all   = {16'h0000, st.keep_a};
   assign sel_in_all = {PERIPH_SEL_B_I, PERIPH_SEL_A_I};

   for (genvar i = 0; i < 32; i++) begin : g_gate
      pcg_gate_cell u_cell (
         .clk_i     (CLK_I),
         .reset_n_i (RESET_N_I),
         .enable_i  (en_all[i]),
         .keep_i    (keep_all[i]),
         .run_i     (st.mode == pcg_pkg::MODE_RUN),
         .sel_i     (sel_in_all[i]),
         .clk_en_o  (clk_en_all[i]),
         .sel_o     (sel_out_all[i])
      );
   end

   assign CLK_EN_A_O     = clk_en_all[15:0];
   assign CLK_EN_B_O     = clk_en_all[31:16];
   assign PERIPH_SEL_A_O = sel_out_all[15:0];
   assign PERIPH_SEL_B_O = sel_out_all[31:16];

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   a_reset_gates_off: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      $rose(RESET_N_I) |-> (CLK_EN_A_O == '0 && st.gate_a == '0))
      else $error("group A clocks not off after reset");

   a_run_clk_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      (st.mode == pcg_pkg::MODE_RUN) |=> (CLK_EN_A_O == $past(st.gate_a)))
      else $error("group A clock enables do not follow register in run");

   a_run_clk_b: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      (st.mode == pcg_pkg::MODE_RUN) |=> (CLK_EN_B_O == $past(st.gate_b)))
      else $error("group B clock enables do not follow register in run");

   a_stop_all_b: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      st.in_stop |=> (CLK_EN_B_O == '0))
      else $error("group B clock running in stop");

   a_stop_keep_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      st.in_stop |=> (CLK_EN_A_O == $past(st.gate_a & st.keep_a)))
      else $error("group A stop clocks differ from enable and keep");

   a_wake_exit: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      (st.in_stop && |(IRQ_A_I & CLK_EN_A_O))
         |=> (WAKE_O && !STOP_MODE_O) ##1 !WAKE_O)
      else $error("kept-alive interrupt did not wake for one cycle");

   a_sel_gated: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      ##1 ((PERIPH_SEL_A_O & ~$past(st.gate_a)) == '0))
      else $error("select passed to a peripheral with clock off");

   a_guard_blocks: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      (wr_go && wr.addr == pcg_pkg::ADDR_GATE_A && st.guard[pcg_pkg::GUARD_ON])
         |=> $stable(st.gate_a))
      else $error("guarded enable register changed");

   a_guard_locked: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      st.guard[pcg_pkg::GUARD_LOCK] |=> $stable(st.guard))
      else $error("locked guard changed");

   a_reserved_zero: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      ((st.gate_a & ~pcg_pkg::MASK_GATE_A) == '0)
         && ((st.gate_b & ~pcg_pkg::MASK_GATE_B) == '0))
      else $error("reserved enable bit set");

   c_enter_stop: cover property (@(posedge CLK_I) disable iff (!RESET_N_I)
      $rose(st.in_stop));
   c_wake_up: cover property (@(posedge CLK_I) disable iff (!RESET_N_I)
      WAKE_O);
   c_guard_hit: cover property (@(posedge CLK_I) disable iff (!RESET_N_I)
      wr_go && st.guard[pcg_pkg::GUARD_ON]);
   c_kept_clock: cover property (@(posedge CLK_I) disable iff (!RESET_N_I)
      st.in_stop && (CLK_EN_A_O != '0));

endmodule : pcg_top

// ### common/pcg_pkg.sv
// Package of constants and types for the peripheral clock gating block
package pcg_pkg;

   // Bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W  = 16;
   localparam int NUM_A  = 16;
   localparam int NUM_B  = 16;

   // Register indices as printed; byte address is four times the index
   localparam logic [7:0] IDX_GATE_A = 8'h0c;
   localparam logic [7:0] IDX_GATE_B = 8'h0d;
   localparam logic [7:0] IDX_KEEP_A = 8'h0e;
   localparam logic [7:0] IDX_GUARD  = 8'h12;
   localparam logic [7:0] IDX_STATUS = 8'h14;
   localparam logic [7:0] IDX_LIVE   = 8'h15;

   localparam logic [7:0] ADDR_GATE_A = {IDX_GATE_A[5:0], 2'h0};
   localparam logic [7:0] ADDR_GATE_B = {IDX_GATE_B[5:0], 2'h0};
   localparam logic [7:0] ADDR_KEEP_A = {IDX_KEEP_A[5:0], 2'h0};
   localparam logic [7:0] ADDR_GUARD  = {IDX_GUARD[5:0], 2'h0};
   localparam logic [7:0] ADDR_STATUS = {IDX_STATUS[5:0], 2'h0};
   localparam logic [7:0] ADDR_LIVE   = {IDX_LIVE[5:0], 2'h0};

   // Implemented bits; all other positions are reserved and held at zero
   localparam logic [15:0] MASK_GATE_A = 16'hf455;
   localparam logic [15:0] MASK_GATE_B = 16'h700f;
   localparam logic [15:0] MASK_KEEP_A = 16'hf455;

   // Reset values
   localparam logic [15:0] RST_GATE_A = 16'h0000;
   localparam logic [15:0] RST_GATE_B = 16'h0000;
   localparam logic [15:0] RST_KEEP_A = 16'h0000;
   localparam logic [1:0]  RST_GUARD  = 2'h0;

   // Write guard field sits in bits 3:2 of its register
   localparam int GUARD_LSB  = 2;
   localparam int GUARD_ON   = 0;
   localparam int GUARD_LOCK = 1;
   localparam int STAT_STOP  = 0;

   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Power mode of the chip as seen by the gating logic
   typedef enum logic {MODE_RUN, MODE_STOP} pcg_mode_type;

   // Register write request handed from the bus slave to the register file
   typedef struct packed {
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   data;
      logic [DATA_W/8-1:0] strb;
   } pcg_wr_type;

endpackage : pcg_pkg

// ### rtl/pcg_gate_cell.sv
// One peripheral clock enable with stop keep-alive and access qualification
module pcg_gate_cell (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   // Control
   input  wire logic enable_i,
   input  wire logic keep_i,
   input  wire logic run_i,
   // Peripheral bus select from the address decoder
   input  wire logic sel_i,
   // Gated results
   output logic      clk_en_o,
   output logic      sel_o
);

   typedef struct packed {
      logic clk_en;
      logic sel;
   } pcg_cell_type;

   pcg_cell_type st;
   pcg_cell_type next_st;
   logic         live;

   // Clock runs when enabled, and in stop only when also kept alive
   always_comb begin
      live           = enable_i & (run_i | keep_i);
      next_st.clk_en = live;
      // A select never reaches a peripheral whose clock is off
      next_st.sel    = sel_i & live;
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign clk_en_o = st.clk_en;
   assign sel_o    = st.sel;

endmodule : pcg_gate_cell

// ### rtl/pcg_axil_slave.sv
// AXI4-Lite slave front end that turns bus transfers into register requests
module pcg_axil_slave (
   // Clock and reset
   input  wire logic                       clk_i,
   input  wire logic                       reset_n_i,
   // Write channels
   input  wire logic [pcg_pkg::ADDR_W-1:0] awaddr_i,
   input  wire logic                       awvalid_i,
   output logic                            awready_o,
   input  wire logic [pcg_pkg::DATA_W-1:0] wdata_i,
   input  wire logic [3:0]                 wstrb_i,
   input  wire logic                       wvalid_i,
   output logic                            wready_o,
   output logic [1:0]                      bresp_o,
   output logic                            bvalid_o,
   input  wire logic                       bready_i,
   // Read channels
   input  wire logic [pcg_pkg::ADDR_W-1:0] araddr_i,
   input  wire logic                       arvalid_i,
   output logic                            arready_o,
   output logic [pcg_pkg::DATA_W-1:0]      rdata_o,
   output logic [1:0]                      rresp_o,
   output logic                            rvalid_o,
   input  wire logic                       rready_i,
   // Register file side
   output pcg_pkg::pcg_wr_type             wr_o,
   output logic                            wr_go_o,
   input  wire logic                       wr_hit_i,
   output logic [pcg_pkg::ADDR_W-1:0]      rd_addr_o,
   input  wire logic [pcg_pkg::DATA_W-1:0] rd_data_i,
   input  wire logic                       rd_hit_i
);

   typedef struct packed {
      logic                       aw_full;
      logic                       w_full;
      logic                       awready;
      logic                       wready;
      logic                       bvalid;
      logic [1:0]                 bresp;
      logic                       arready;
      logic                       rd_pend;
      logic                       rvalid;
      logic [1:0]                 rresp;
      logic [pcg_pkg::DATA_W-1:0] rdata;
      logic [pcg_pkg::ADDR_W-1:0] rd_addr;
      pcg_pkg::pcg_wr_type        wr;
      logic                       wr_go;
   } pcg_slave_type;

   pcg_slave_type st;
   pcg_slave_type next_st;

   // Address and data are parked separately, so either may come first
   always_comb begin
      next_st       = st;
      next_st.wr_go = 1'b0;
      if (st.bvalid && bready_i) begin
         next_st.bvalid = 1'b0;
      end
      if (awvalid_i && st.awready) begin
         next_st.wr.addr = awaddr_i;
         next_st.aw_full = 1'b1;
      end
      if (wvalid_i && st.wready) begin
         next_st.wr.data = wdata_i;
         next_st.wr.strb = wstrb_i;
         next_st.w_full  = 1'b1;
      end
      // Issue only once the previous response has gone
      if (st.aw_full && st.w_full && !st.bvalid) begin
         next_st.wr_go   = 1'b1;
         next_st.aw_full = 1'b0;
         next_st.w_full  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = wr_hit_i ? pcg_pkg::RESP_OKAY : pcg_pkg::RESP_SLVERR;
      end
      next_st.awready = !next_st.aw_full;
      next_st.wready  = !next_st.w_full;
      // Read path: one cycle to look the register up, then answer
      if (st.rvalid && rready_i) begin
         next_st.rvalid = 1'b0;
      end
      if (arvalid_i && st.arready) begin
         next_st.rd_addr = araddr_i;
         next_st.rd_pend = 1'b1;
      end
      if (st.rd_pend) begin
         next_st.rd_pend = 1'b0;
         next_st.rvalid  = 1'b1;
         next_st.rdata   = rd_data_i;
         next_st.rresp   = rd_hit_i ? pcg_pkg::RESP_OKAY : pcg_pkg::RESP_SLVERR;
      end
      next_st.arready = !next_st.rd_pend && !next_st.rvalid;
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign awready_o = st.awready;
   assign wready_o  = st.wready;
   assign bvalid_o  = st.bvalid;
   assign bresp_o   = st.bresp;
   assign arready_o = st.arready;
   assign rvalid_o  = st.rvalid;
   assign rresp_o   = st.rresp;
   assign rdata_o   = st.rdata;
   assign rd_addr_o = st.rd_addr;
   assign wr_o      = st.wr;
   assign wr_go_o   = st.wr_go;

endmodule : pcg_axil_slave

// ### tb/pcg_periph_model.sv
// Model of the gated peripherals that raise wake interrupts
module pcg_periph_model (
   // Clock
   input  wire logic        clk_i,
   // Live clock enables and bench request to interrupt
   input  wire logic [15:0] clk_en_i,
   input  wire logic [15:0] fire_i,
   // Interrupt lines
   output logic      [15:0] irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // An unclocked unit is held disabled, so only a live one can interrupt
   always_ff @(posedge clk_i) begin
      irq_o <= fire_i & clk_en_i;
   end
endmodule : pcg_periph_model

// ### tb/pcg_tb_top.sv
// Self-checking bench for the peripheral clock gating block
module pcg_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_n, awv, wv, arv, stop_req, w;
   logic        awr, wrr, bv, arr, rv, stop_o, wake;
   logic [7:0]  awa, ara;
   logic [31:0] wd, rd, rdo;
   logic [15:0] sel_a, sel_b, fire, irq_a, en_a, en_b, so_a, gate, keep, seed, so_b, irq_b;
   logic [1:0]  rs, br, rr;
   int          n_errors, check_count, cyc;
   localparam logic [15:0] MA = pcg_pkg::MASK_GATE_A;
   pcg_top pcg_top_i (.CLK_I(clk), .RESET_N_I(rst_n), .AWADDR_I(awa), .AWVALID_I(awv),
      .AWREADY_O(awr), .WDATA_I(wd), .WSTRB_I(4'hf), .WVALID_I(wv), .WREADY_O(wrr),
      .BRESP_O(br), .BVALID_O(bv), .BREADY_I(1'b1), .ARADDR_I(ara), .ARVALID_I(arv),
      .ARREADY_O(arr), .RDATA_O(rdo), .RRESP_O(rr), .RVALID_O(rv), .RREADY_I(1'b1),
      .STOP_REQ_I(stop_req), .STOP_MODE_O(stop_o), .WAKE_O(wake), .IRQ_A_I(irq_a),
      .IRQ_B_I(irq_b), .PERIPH_SEL_A_I(sel_a), .PERIPH_SEL_B_I(sel_b),
      .CLK_EN_A_O(en_a), .CLK_EN_B_O(en_b), .PERIPH_SEL_A_O(so_a), .PERIPH_SEL_B_O(so_b));
   pcg_periph_model pcg_periph_model_i (.clk_i(clk), .clk_en_i(en_a), .fire_i(fire),
      .irq_o(irq_a));
   ////////////////////////////////////////
   // Free-running system clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Cut a hang short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         stop_test();
      end
   end
   // Galois shift register for repeatable random data
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
   endfunction : lfsr
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Write; each channel released at the edge that takes it
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      tb = 1'b0;
      while (!tb) begin
         @(negedge clk);
         ta = awv & awr;
         tw = wv & wrr;
         tb = bv;
         rs = br;
         @(posedge clk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
      end
   endtask : wr
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      logic ta, tr;
      ara <= a;
      arv <= 1'b1;
      tr = 1'b0;
      while (!tr) begin
         @(negedge clk);
         ta = arv & arr;
         tr = rv;
         d = rdo;
         rs = rr;
         @(posedge clk);
         if (ta) arv <= 1'b0;
      end
   endtask : rd_reg
   task automatic stop_test();
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : stop_test
   // Main sequence
   initial begin
      {rst_n, awv, wv, arv, stop_req, w} = '0;
      {awa, ara, wd, sel_a, sel_b, fire, irq_b} = '0;
      seed = 16'h0024;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      rd_reg(pcg_pkg::ADDR_GATE_A, rd);
      chk(rd, 32'h0);
      rd_reg(pcg_pkg::ADDR_KEEP_A, rd);
      chk(rd, 32'h0);
      $display("reset test done");
      for (int i = 0; i < 9; i++) begin
         seed = lfsr(seed);
         gate = (i == 8) ? 16'hffff : seed;
         sel_a <= lfsr(seed);
         sel_b <= ~seed;
         wr(pcg_pkg::ADDR_GATE_A, {16'h0, gate});
         wr(pcg_pkg::ADDR_GATE_B, {16'h0, gate});
         rd_reg(pcg_pkg::ADDR_GATE_A, rd);
         chk(rd, {16'h0, gate & MA});
         @(negedge clk);
         chk({16'h0, en_a}, {16'h0, gate & MA});
         chk({16'h0, en_a}, {16'h0, gate & MA});
         chk({16'h0, en_b}, {16'h0, gate & pcg_pkg::MASK_GATE_B});
         chk({16'h0, so_a}, {16'h0, sel_a & gate & MA});
         chk({16'h0, so_b}, {16'h0, sel_b & gate & pcg_pkg::MASK_GATE_B});
         @(posedge clk);
      end
      $display("gating test done");
      keep = 16'h0401;
      wr(pcg_pkg::ADDR_KEEP_A, {16'h0, keep});
      stop_req <= 1'b1;
      @(posedge clk);
      stop_req <= 1'b0;
      repeat (2) @(posedge clk);
      // Non-kept units fire only once their clocks have stopped, as software must ensure
      fire  <= 16'h0010;
      irq_b <= 16'hffff;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk({31'h0, stop_o}, 32'h1);
      chk({16'h0, en_a}, {16'h0, gate & keep & MA});
      chk({16'h0, en_b}, 32'h0);
      @(posedge clk);
      rd_reg(pcg_pkg::ADDR_STATUS, rd);
      chk(rd, 32'h1);
      fire  <= 16'h0400;
      irq_b <= 16'h0000;
      repeat (20) begin
         @(negedge clk);
         if (wake === 1'b1) w = 1'b1;
      end
      chk({31'h0, w}, 32'h1);
      chk({16'h0, en_a}, {16'h0, gate & MA});
      @(posedge clk);
      fire <= 16'h0000;
      $display("stop test done");
      wr(pcg_pkg::ADDR_GUARD, 32'h4);
      wr(pcg_pkg::ADDR_GATE_A, 32'h0);
      chk({30'h0, rs}, {30'h0, pcg_pkg::RESP_OKAY});
      rd_reg(pcg_pkg::ADDR_GATE_A, rd);
      chk(rd, {16'h0, gate & MA});
      wr(pcg_pkg::ADDR_GUARD, 32'h0);
      rd_reg(8'hfc, rd);
      chk({30'h0, rs}, {30'h0, pcg_pkg::RESP_SLVERR});
      // Guard on and locked: a later clear must not take
      wr(pcg_pkg::ADDR_GUARD, 32'hc);
      wr(pcg_pkg::ADDR_GUARD, 32'h0);
      rd_reg(pcg_pkg::ADDR_GUARD, rd);
      chk(rd, 32'hc);
      $display("guard test done");
      // Only a chip reset frees the lock and clears the enables
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      rd_reg(pcg_pkg::ADDR_GATE_A, rd);
      chk(rd, 32'h0);
      rd_reg(pcg_pkg::ADDR_GUARD, rd);
      chk(rd, 32'h0);
      $display("second reset test done");
      stop_test();
   end
endmodule : pcg_tb_top
